// >>> hw/gxp_pkg.sv
/*
  Shared constants and helpers for the gigabit / XAUI idle ordered-set
  coding layer: code-group values, lane geometry, idle timing and the
  running-disparity helper.
  Assumes a 4-lane code-group datapath, one code group per lane per cycle.
*/
`default_nettype none

package gxp_pkg;

  localparam int unsigned LANES    = 4;
  localparam int unsigned SYM_W    = 8;
  localparam int unsigned DATA_W   = LANES * SYM_W;
  localparam int unsigned WORD_W   = DATA_W + LANES + 1;
  localparam int unsigned FIFO_DEP = 8;

  // Code groups (byte value, control flag carried separately)
  localparam logic [7:0] K28_5     = 8'hbc;
  localparam logic [7:0] K28_0     = 8'h1c;
  localparam logic [7:0] K28_3     = 8'h7c;
  localparam logic [7:0] D21_5     = 8'hb5;
  localparam logic [7:0] D2_2      = 8'h42;
  localparam logic [7:0] D5_6      = 8'hc5;
  localparam logic [7:0] D16_2     = 8'h50;
  localparam logic [7:0] XGMII_IDL = 8'h07;

  // Configuration-set substitution period, in configuration sets; groups replaced after the kept comma
  localparam int unsigned SUB_PERIOD = 16;
  localparam int unsigned SUB_LEFT   = 3;

  // Randomised idle timing, in columns
  localparam logic [4:0] A_MIN      = 5'h10;
  localparam logic [6:0] LFSR_SEED  = 7'h7f;

  typedef enum logic [1:0]
  {
    GXP_COL_A = 2'b00,
    GXP_COL_K = 2'b01,
    GXP_COL_R = 2'b10
  } gxp_col_t;

  // True when the code group flips running disparity
  function automatic logic gxp_rd_flip(input logic [7:0] sym,
                                       input logic       ctl);
    logic u6;
    logic u4;
    u6 = sym[4:0] inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h0f,
                          5'h10, 5'h17, 5'h18, 5'h1b, 5'h1d, 5'h1e,
                          5'h1f} || (ctl && sym[4:0] == 5'h1c);
    u4 = sym[7:5] inside {3'h0, 3'h4, 3'h7};
    return u6 ^ u4;
  endfunction : gxp_rd_flip

endpackage : gxp_pkg

`default_nettype wire

// >>> hw/gxp_if.sv
/*
  Carrier between the fabric MAC/auto-negotiation end and the coding
  layer end. Transmit words flow with valid/ready, receive words with
  valid only. Both ends run on the same clock outside this interface.
*/
`timescale 1ns/10ps
`default_nettype none

interface gxp_if;
  import gxp_pkg::*;

  logic [DATA_W-1:0] tx_data;
  logic [LANES-1:0]  tx_ctrl;
  logic              tx_cordisp;
  logic              tx_valid;
  logic              tx_ready;
  logic              an_xmit;
  logic              xaui_mode;
  logic [DATA_W-1:0] rx_data;
  logic [LANES-1:0]  rx_ctrl;
  logic              rx_valid;

  modport pcs
  (
    input  tx_data, tx_ctrl, tx_cordisp, tx_valid, an_xmit, xaui_mode,
    output tx_ready, rx_data, rx_ctrl, rx_valid
  );

  modport fab
  (
    output tx_data, tx_ctrl, tx_cordisp, tx_valid, an_xmit, xaui_mode,
    input  tx_ready, rx_data, rx_ctrl, rx_valid
  );

endinterface : gxp_if

`default_nettype wire

// >>> hw/gxp_pcs.sv
/*
  Coding-layer end: transmit FIFO, idle and disparity handling toward the
  PMA, and receive configuration-set substitution toward the fabric.
  Assumes the PMA encodes each byte with the running disparity given
  beside it, and that receive code groups arrive on CLK_IN already.
*/
`timescale 1ns/10ps
`default_nettype none

module gxp_fifo
  import gxp_pkg::*;
#(
  parameter int unsigned W = WORD_W,
  parameter int unsigned D = FIFO_DEP
)
(
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  localparam int unsigned AW = $clog2(D);

  typedef struct packed
  {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } gxp_fifo_st_t;

  gxp_fifo_st_t st_ff;
  gxp_fifo_st_t nxt_st;
  logic         push;
  logic         pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  assign in_ready_out  = (st_ff.cnt != (AW + 1)'(D));
  assign out_valid_out = (st_ff.cnt != '0);
  assign out_data_out  = st_ff.mem[st_ff.rp];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data_in;
      nxt_st.wp            = ptr_inc(st_ff.wp);
    end
    if (pop)
      nxt_st.rp = ptr_inc(st_ff.rp);
    if (push && !pop)
      nxt_st.cnt = (AW + 1)'(st_ff.cnt + 1'b1);
    else if (pop && !push)
      nxt_st.cnt = (AW + 1)'(st_ff.cnt - 1'b1);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_ff <= '0;
    else if (ce_in)
      st_ff <= nxt_st;
  end
endmodule : gxp_fifo

module gxp_pcs
  import gxp_pkg::*;
#(
  parameter int unsigned SUB_EVERY = SUB_PERIOD,
  parameter int unsigned TX_DEPTH  = FIFO_DEP
)
(
  input  wire logic              CLK_IN,
  input  wire logic              RESET_N_IN,
  input  wire logic              CE_IN,
  gxp_if.pcs                     lnk,
  output logic [DATA_W-1:0]      PMA_TX_DATA_OUT,
  output logic [LANES-1:0]       PMA_TX_CTRL_OUT,
  output logic [LANES-1:0]       PMA_TX_RD_OUT,
  output logic                   PMA_TX_VALID_OUT,
  input  wire logic              PMA_TX_READY_IN,
  input  wire logic [DATA_W-1:0] PMA_RX_DATA_IN,
  input  wire logic [LANES-1:0]  PMA_RX_CTRL_IN,
  input  wire logic              PMA_RX_VALID_IN
);
  typedef struct packed
  {
    logic [DATA_W-1:0] tx_data;
    logic [LANES-1:0]  tx_ctrl;
    logic [LANES-1:0]  tx_rd_out;
    logic              tx_valid;
    logic [LANES-1:0]  rd;
    logic              fix_pend;
    logic [6:0]        lfsr;
    logic [4:0]        a_cnt;
    logic [DATA_W-1:0] s1_data;
    logic [LANES-1:0]  s1_ctrl;
    logic              s1_vld;
    logic [1:0]        sub_cnt;
    logic [7:0]        per_cnt;
    logic [DATA_W-1:0] rx_data;
    logic [LANES-1:0]  rx_ctrl;
    logic              rx_valid;
  } gxp_pcs_st_t;

  gxp_pcs_st_t       st_ff;
  gxp_pcs_st_t       nxt_st;
  logic              f_valid;
  logic [WORD_W-1:0] f_word;
  logic              f_pop;
  logic [DATA_W-1:0] w_data;
  logic [LANES-1:0]  w_ctrl;
  logic              w_cord;
  logic              idle_col;
  gxp_col_t          col;
  logic [7:0]        col_sym;
  logic              cfg_next;

  // Eight words absorb PMA stalls; fabric sees them through tx_ready
  gxp_fifo #(.W(WORD_W), .D(TX_DEPTH)) u_txq
  (
    .clk_in        (CLK_IN),
    .rst_n_in      (RESET_N_IN),
    .ce_in         (CE_IN),
    .in_valid_in   (lnk.tx_valid),
    .in_data_in    ({lnk.tx_cordisp, lnk.tx_ctrl, lnk.tx_data}),
    .in_ready_out  (lnk.tx_ready),
    .out_valid_out (f_valid),
    .out_data_out  (f_word),
    .out_ready_in  (f_pop)
  );

  assign f_pop  = f_valid && (PMA_TX_READY_IN || !st_ff.tx_valid);
  assign w_data = f_word[DATA_W-1:0];
  assign w_ctrl = f_word[DATA_W+LANES-1:DATA_W];
  assign w_cord = f_word[WORD_W-1];

  // An idle column is all four lanes carrying the XGMII idle control
  assign idle_col = (w_ctrl == '1) &&
                    (w_data == {LANES{XGMII_IDL}});

  always_comb
  begin
    if (st_ff.a_cnt == '0)
      col = GXP_COL_A;
    else if (st_ff.lfsr[0])
      col = GXP_COL_K;
    else
      col = GXP_COL_R;
    unique case (col)
      GXP_COL_A: col_sym = K28_5;
      GXP_COL_K: col_sym = K28_0;
      GXP_COL_R: col_sym = K28_3;
    endcase
  end

  assign cfg_next = PMA_RX_VALID_IN && !PMA_RX_CTRL_IN[0] &&
                    (PMA_RX_DATA_IN[SYM_W-1:0] == D21_5 ||
                     PMA_RX_DATA_IN[SYM_W-1:0] == D2_2);

  always_comb
  begin
    nxt_st = st_ff;
    // Transmit: one word per PMA acceptance
    if (PMA_TX_READY_IN)
      nxt_st.tx_valid = 1'b0;
    if (f_pop)
    begin
      nxt_st.tx_valid  = 1'b1;
      nxt_st.tx_data   = w_data;
      nxt_st.tx_ctrl   = w_ctrl;
      nxt_st.tx_rd_out = st_ff.rd;
      if (lnk.xaui_mode)
      begin
        if (idle_col)
        begin
          nxt_st.tx_data = {LANES{col_sym}};
          if (col == GXP_COL_A)
            nxt_st.a_cnt = A_MIN + {1'b0, st_ff.lfsr[3:0]};
        end
        // Data at a zero count holds it, so the next idle is a sync
        if (st_ff.a_cnt != '0)
          nxt_st.a_cnt = st_ff.a_cnt - 1'b1;
        nxt_st.lfsr = {st_ff.lfsr[5:0],
                       st_ff.lfsr[6] ^ st_ff.lfsr[5]};
        for (int l = 0; l < LANES; l++)
          nxt_st.rd[l] = st_ff.rd[l] ^
            gxp_rd_flip(nxt_st.tx_data[l*SYM_W +: SYM_W],
                        w_ctrl[l]);
      end
      else
      begin
        nxt_st.tx_data[DATA_W-1:SYM_W] = '0;
        nxt_st.tx_ctrl[LANES-1:1]      = '0;
        nxt_st.fix_pend = 1'b0;
        // Disparity is sampled before the comma of the first gap set
        if (w_cord && w_ctrl[0] && w_data[SYM_W-1:0] == K28_5)
          nxt_st.fix_pend = st_ff.rd[0];
        if (st_ff.fix_pend && !w_ctrl[0] &&
            w_data[SYM_W-1:0] == D16_2)
          nxt_st.tx_data[SYM_W-1:0] = D5_6;
        nxt_st.rd[0] = st_ff.rd[0] ^
          gxp_rd_flip(nxt_st.tx_data[SYM_W-1:0], w_ctrl[0]);
      end
    end
    // Receive: one stage of lookahead to spot a configuration set
    nxt_st.s1_data  = PMA_RX_DATA_IN;
    nxt_st.s1_ctrl  = PMA_RX_CTRL_IN;
    nxt_st.s1_vld   = PMA_RX_VALID_IN;
    nxt_st.rx_valid = st_ff.s1_vld;
    if (st_ff.s1_vld)
    begin
      nxt_st.rx_data = st_ff.s1_data;
      nxt_st.rx_ctrl = st_ff.s1_ctrl;
      if (!lnk.xaui_mode && st_ff.sub_cnt != '0)
      begin
        // Three groups after the kept comma make two whole /I2/ sets
        nxt_st.rx_data[SYM_W-1:0] = st_ff.sub_cnt[0] ? D16_2 : K28_5;
        nxt_st.rx_ctrl[0]         = !st_ff.sub_cnt[0];
        nxt_st.sub_cnt            = st_ff.sub_cnt - 1'b1;
      end
      else if (!lnk.xaui_mode && st_ff.s1_ctrl[0] &&
               st_ff.s1_data[SYM_W-1:0] == K28_5 && cfg_next)
      begin
        if (lnk.an_xmit && st_ff.per_cnt == 8'(SUB_EVERY - 1))
        begin
          nxt_st.sub_cnt = 2'(SUB_LEFT);
          nxt_st.per_cnt = '0;
        end
        else if (lnk.an_xmit)
          nxt_st.per_cnt = st_ff.per_cnt + 1'b1;
        else
          nxt_st.per_cnt = '0;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      st_ff      <= '0;
      st_ff.lfsr <= LFSR_SEED;
    end
    else if (CE_IN)
      st_ff <= nxt_st;
  end

  assign PMA_TX_DATA_OUT  = st_ff.tx_data;
  assign PMA_TX_CTRL_OUT  = st_ff.tx_ctrl;
  assign PMA_TX_RD_OUT    = st_ff.tx_rd_out;
  assign PMA_TX_VALID_OUT = st_ff.tx_valid;
  assign lnk.rx_data      = st_ff.rx_data;
  assign lnk.rx_ctrl      = st_ff.rx_ctrl;
  assign lnk.rx_valid     = st_ff.rx_valid;
endmodule : gxp_pcs

`default_nettype wire

// >>> hw/gxp_fab.sv
/*
  Fabric end: MAC-side transmit source that fills gaps with idles and
  pulses the disparity-correct request, plus auto-negotiation state and
  receive capture. Assumes gigabit frames hold an even number of groups.
*/
`timescale 1ns/10ps
`default_nettype none

module gxp_fab
  import gxp_pkg::*;
(
  input  wire logic              CLK_IN,
  input  wire logic              RESET_N_IN,
  input  wire logic              CE_IN,
  input  wire logic              MODE_XAUI_IN,
  input  wire logic              AN_ACTIVE_IN,
  input  wire logic              USR_TX_VALID_IN,
  input  wire logic [DATA_W-1:0] USR_TX_DATA_IN,
  input  wire logic [LANES-1:0]  USR_TX_CTRL_IN,
  output logic                   USR_TX_READY_OUT,
  output logic [DATA_W-1:0]      USR_RX_DATA_OUT,
  output logic [LANES-1:0]       USR_RX_CTRL_OUT,
  output logic                   USR_RX_VALID_OUT,
  gxp_if.fab                     lnk
);
  typedef struct packed
  {
    logic [DATA_W-1:0] tx_data;
    logic [LANES-1:0]  tx_ctrl;
    logic              tx_cord;
    logic              tx_valid;
    logic              in_gap;
    logic              odd;
    logic              an;
    logic              mode;
    logic [DATA_W-1:0] rx_data;
    logic [LANES-1:0]  rx_ctrl;
    logic              rx_valid;
  } gxp_fab_st_t;

  gxp_fab_st_t st_ff;
  gxp_fab_st_t nxt_st;
  logic        adv;
  logic        take;

  // The word on the link moves on only when the coding layer has room
  assign adv  = lnk.tx_ready || !st_ff.tx_valid;
  // A started /I2/ pair is finished before frame data resumes unless MODE_XAUI_IN rises right after its comma
  assign take = adv && !(st_ff.odd && !st_ff.mode);
  assign USR_TX_READY_OUT = take;

  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.an       = AN_ACTIVE_IN;
    nxt_st.mode     = MODE_XAUI_IN;
    nxt_st.rx_data  = lnk.rx_data;
    nxt_st.rx_ctrl  = lnk.rx_ctrl;
    nxt_st.rx_valid = lnk.rx_valid;
    // Word choice follows the mode pin directly, so the first word after
    // reset already matches the mode flagged beside it on the link
    if (adv)
    begin
      nxt_st.tx_valid = 1'b1;
      nxt_st.tx_cord  = 1'b0;
      if (!nxt_st.mode && st_ff.odd)
      begin
        nxt_st.tx_data = {{(DATA_W - SYM_W){1'b0}}, D16_2};
        nxt_st.tx_ctrl = '0;
        nxt_st.odd     = 1'b0;
      end
      else if (USR_TX_VALID_IN)
      begin
        nxt_st.tx_data = USR_TX_DATA_IN;
        nxt_st.tx_ctrl = USR_TX_CTRL_IN;
        nxt_st.in_gap  = 1'b0;
      end
      else if (nxt_st.mode)
      begin
        nxt_st.tx_data = {LANES{XGMII_IDL}};
        nxt_st.tx_ctrl = '1;
      end
      else
      begin
        nxt_st.tx_data = {{(DATA_W - SYM_W){1'b0}}, K28_5};
        nxt_st.tx_ctrl = {{(LANES - 1){1'b0}}, 1'b1};
        nxt_st.tx_cord = !st_ff.in_gap;
        nxt_st.in_gap  = 1'b1;
        nxt_st.odd     = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      st_ff <= '0;
    else if (CE_IN)
      st_ff <= nxt_st;
  end

  assign lnk.tx_data    = st_ff.tx_data;
  assign lnk.tx_ctrl    = st_ff.tx_ctrl;
  assign lnk.tx_cordisp = st_ff.tx_cord;
  assign lnk.tx_valid   = st_ff.tx_valid;
  assign lnk.an_xmit    = st_ff.an;
  assign lnk.xaui_mode  = st_ff.mode;
  assign USR_RX_DATA_OUT  = st_ff.rx_data;
  assign USR_RX_CTRL_OUT  = st_ff.rx_ctrl;
  assign USR_RX_VALID_OUT = st_ff.rx_valid;
endmodule : gxp_fab

`default_nettype wire

// >>> dv/gxp_assertions.sv
/*
  Checker on the link between the fabric end and the coding-layer end.
  Assumes one clock, async active-low reset, CE_IN held high.
*/
`timescale 1ns/10ps
`default_nettype none

module gxp_assertions
  import gxp_pkg::*;
(
  input wire logic              CLK_IN,
  input wire logic              RESET_N_IN,
  input wire logic              CE_IN,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic [LANES-1:0]  tx_ctrl,
  input wire logic              tx_cordisp,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic              xaui_mode
);
  logic [1:0] up_ff;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  // Source is idle-free only on the first edge after reset
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN)
      up_ff <= 2'h0;
    else if (up_ff != 2'h2)
      up_ff <= up_ff + 2'h1;

  sequence s_comma_take;
    !xaui_mode && tx_valid && tx_ready && CE_IN && tx_ctrl[0]
      && tx_data[7:0] == K28_5;
  endsequence

  sequence s_i2_tail;
    tx_valid && !tx_ctrl[0] && tx_data[7:0] == D16_2;
  endsequence

  a_cordisp_single: assert property (
    tx_cordisp && tx_valid && tx_ready && CE_IN |=> !tx_cordisp)
    else $error("correct request longer than one word");
  a_cordisp_comma: assert property (
    tx_cordisp && tx_valid |-> !xaui_mode && tx_ctrl[0]
      && tx_data[7:0] == K28_5)
    else $error("correct request off a comma");
  a_cordisp_then_i2: assert property (
    (s_comma_take ##0 tx_cordisp) |=> s_i2_tail)
    else $error("gap start not followed by D16.2");
  a_comma_pair: assert property (
    s_comma_take |=> tx_valid && !tx_ctrl[0] && tx_data[7:0] != D5_6)
    else $error("comma not paired with an idle data group");
  a_tx_word_holds: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
      && $stable(tx_ctrl) && $stable(tx_cordisp))
    else $error("refused word changed");
  a_xaui_no_cordisp: assert property (
    xaui_mode |-> !tx_cordisp)
    else $error("correct request in four-lane mode");
  a_xaui_idle_col: assert property (
    xaui_mode && tx_valid && tx_ctrl == 4'hf
      |-> tx_data == {LANES{XGMII_IDL}})
    else $error("malformed idle column");
  a_gap_filled: assert property (
    up_ff == 2'h2 |-> tx_valid)
    else $error("link left without idles");

endmodule : gxp_assertions

`default_nettype wire

// >>> dv/gxp_pcs_tb.sv
/*
  Testbench: fabric end and coding-layer end joined by the link; the
  bench plays user and PMA. Assumes a 25 MHz clock, CE held high.
*/
`timescale 1ns/10ps
`default_nettype none

module gxp_pcs_tb;
  import gxp_pkg::*;

  logic              clk, rst_n, ce, mode_x, an_on;
  logic              usr_tv, usr_tr, usr_rv, pma_tv, pma_tr, pma_rv;
  logic [DATA_W-1:0] usr_td, usr_rd, pma_td, pma_rdat;
  logic [LANES-1:0]  usr_tc, usr_rc, pma_tc, pma_trd, pma_rc;
  int                n_mismatch, check_count, cyc;

  gxp_if lnk ();

  // Short substitution period keeps the receive run brief
  gxp_pcs #(.SUB_EVERY(2)) gxp_pcs_i (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce), .lnk(lnk),
    .PMA_TX_DATA_OUT(pma_td), .PMA_TX_CTRL_OUT(pma_tc),
    .PMA_TX_RD_OUT(pma_trd), .PMA_TX_VALID_OUT(pma_tv),
    .PMA_TX_READY_IN(pma_tr), .PMA_RX_DATA_IN(pma_rdat),
    .PMA_RX_CTRL_IN(pma_rc), .PMA_RX_VALID_IN(pma_rv));

  gxp_fab gxp_fab_i (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce), .MODE_XAUI_IN(mode_x),
    .AN_ACTIVE_IN(an_on), .USR_TX_VALID_IN(usr_tv),
    .USR_TX_DATA_IN(usr_td), .USR_TX_CTRL_IN(usr_tc),
    .USR_TX_READY_OUT(usr_tr), .USR_RX_DATA_OUT(usr_rd),
    .USR_RX_CTRL_OUT(usr_rc), .USR_RX_VALID_OUT(usr_rv), .lnk(lnk));

  gxp_assertions gxp_assertions_i (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
    .tx_data(lnk.tx_data), .tx_ctrl(lnk.tx_ctrl),
    .tx_cordisp(lnk.tx_cordisp), .tx_valid(lnk.tx_valid),
    .tx_ready(lnk.tx_ready), .xaui_mode(lnk.xaui_mode));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [39:0] seen, exp, input string m);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h want %h",
               $time, m, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic do_reset(input logic x);
    @(negedge clk);
    rst_n = 1'b0;
    mode_x = x;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset

  // Word stands until the edge after ready is seen high
  task automatic send(input logic [31:0] w);
    @(negedge clk);
    usr_tv = 1'b1;
    usr_td = w;
    #1;
    while (usr_tr !== 1'b1)
    begin
      @(negedge clk);
      #1;
    end
  endtask : send

  task automatic frame(input logic [7:0] b);
    send({24'h0, b});
    send(32'h0);
    @(negedge clk);
    usr_tv = 1'b0;
    repeat (10) @(negedge clk);
  endtask : frame

  task automatic t_gig;
    logic       rd_m, rd_c, gap, prev_k, c;
    logic [7:0] w, e;
    int         n_i1;
    {rd_m, rd_c, gap, prev_k, n_i1} = {4'b0010, 32'd0};
    do_reset(1'b0);
    fork
      for (int i = 0; i < 100; i++)
      begin
        @(negedge clk);
        pma_tr = (i % 4 != 3);
        if (pma_tv === 1'b1 && pma_tr)
        begin
          c = pma_tc[0];
          w = pma_td[7:0];
          check(pma_trd[0], rd_m, "tx disparity");
          if (prev_k)
          begin
            e = (gap && rd_c) ? D5_6 : D16_2;
            n_i1 += (e == D5_6);
            gap = 1'b0;
            check({c, w}, {1'b0, e}, "gap idle");
          end
          else if (!c && w != D16_2)
            gap = 1'b1;
          prev_k = c && w == K28_5;
          rd_c = rd_m;
          rd_m = rd_m ^ (c || w inside {D16_2, 8'h03});
        end
      end
      begin
        frame(8'h03);
        frame(8'h00);
        frame(8'h03);
      end
    join
    pma_tr = 1'b1;
    check(n_i1, 2, "one I1 per positive gap");
    $display("done: gigabit disparity");
  endtask : t_gig

  task automatic t_rx;
    logic [8:0] q[$], e[$], s;
    for (int an = 1; an >= 0; an--)
    begin
      q.delete();
      e.delete();
      an_on = an[0];
      repeat (4) @(negedge clk);
      fork
        begin
          for (int k = 0; k < 8; k++)
            for (int j = 0; j < 4; j++)
            begin
              @(negedge clk);
              s = (j == 0) ? {1'b1, K28_5} : (j == 1) ?
                  {1'b0, k[0] ? D2_2 : D21_5} : {7'h0, j[1:0]};
              pma_rv = 1'b1;
              pma_rc = {3'h0, s[8]};
              pma_rdat = {24'h0, s[7:0]};
              if (an == 1 && k[0] && j > 0)
                s = (j == 2) ? {1'b1, K28_5} : {1'b0, D16_2};
              e.push_back(s);
            end
          @(negedge clk);
          pma_rv = 1'b0;
          pma_rdat = ~pma_rdat;
        end
        repeat (44)
        begin
          @(negedge clk);
          if (usr_rv === 1'b1)
            q.push_back({usr_rc[0], usr_rd[7:0]});
        end
      join
      check(q.size(), 32, "rx word count");
      foreach (e[i])
        check(q[i], e[i], "rx word");
    end
    $display("done: receive substitution");
  endtask : t_rx

  task automatic t_fill;
    pma_tr = 1'b0;
    do_reset(1'b0);
    repeat (20) @(negedge clk);
    check(lnk.tx_ready, 1'b0, "full fifo refuses");
    check(usr_tr, 1'b0, "user held off");
    pma_tr = 1'b1;
    repeat (3) @(negedge clk);
    check(lnk.tx_ready, 1'b1, "fifo drains");
    $display("done: fifo fill");
  endtask : t_fill

  task automatic t_xaui;
    int         gap, n_a, n_k, n_r, n_w, n_d;
    logic [7:0] b;
    {gap, n_a, n_k, n_r, n_w, n_d} = '0;
    do_reset(1'b1);
    fork
      for (int i = 0; i < 120; i++)
      begin
        @(negedge clk);
        pma_tr = (i % 5 != 4);
        if (pma_tv === 1'b1 && pma_tr)
        begin
          b = pma_td[7:0];
          if (n_w++ == 0)
            check(b, K28_5, "first column sync");
          if (pma_tc === 4'h0)
          begin
            check(pma_td, 32'h0403_0201, "data column");
            n_d++;
            gap++;
          end
          else
          begin
            check({pma_tc, pma_td, b inside {K28_5, K28_0, K28_3}},
                  {4'hf, {4{b}}, 1'b1}, "idle column");
            if (b == K28_5 && n_a > 0)
              check(gap >= A_MIN && gap <= A_MIN + 15, 1,
                    "sync spacing");
            n_k += (b == K28_0);
            n_r += (b == K28_3);
            n_a += (b == K28_5);
            gap = (b == K28_5) ? 0 : gap + 1;
          end
        end
      end
      begin
        repeat (8) @(negedge clk);
        send(32'h0403_0201);
        @(negedge clk);
        usr_tv = 1'b0;
      end
    join
    check(n_a > 1 && n_k > 0 && n_r > 0 && n_d == 1, 1,
          "column mix");
    $display("done: four-lane idles");
  endtask : t_xaui

  initial
  begin
    {rst_n, ce, mode_x, an_on, usr_tv, pma_tr, pma_rv} = 7'b0100010;
    {usr_td, usr_tc, pma_rdat, pma_rc} = '0;
    {n_mismatch, check_count, cyc} = '0;
    t_gig();
    t_rx();
    t_fill();
    t_xaui();
    tally_and_finish();
  end

endmodule : gxp_pcs_tb

`default_nettype wire
